// ---- rtl/shp_map.svh ----
`ifndef SHP_MAP_SVH
`define SHP_MAP_SVH

// ****************************************************************
// Strap levels
// ****************************************************************
`define SHP_STYLE_SPLIT 1'b1
`define SHP_DRIVE_TRISTATE 1'b1
`define SHP_DRIVE_OPEN 1'b0

// ****************************************************************
// Field positions of the synchronised host pin vector
// ****************************************************************
`define SHP_HP_REGSEL 0
`define SHP_HP_DMASEL 1
`define SHP_HP_RD 2
`define SHP_HP_WR 3
`define SHP_HP_BHE 4
`define SHP_HP_ADDR_LO 5
`define SHP_HP_ADDR_HI 9
`define SHP_HP_DATA_LO 10
`define SHP_HP_DATA_HI 25
`define SHP_HP_PAR_LO 26
`define SHP_HP_PAR_HI 27
`define SHP_HP_WIDTH 28

// ****************************************************************
// Widths, lanes and reset values
// ****************************************************************
`define SHP_LANE_LO 0
`define SHP_LANE_HI 1
`define SHP_SCSI_DATA_W 9
`define SHP_SCSI_CTRL_W 4
`define SHP_SCSI_HS_W 2
`define SHP_ADDR_RST 5'h00
`define SHP_DATA_RST 16'h0000
`define SHP_PAR_RST 2'h0
`define SHP_LANE_RST 2'h0
`define SHP_RESET_MIN_CYCLES 4

`endif

// ---- rtl/shp_pkg.sv ----
package shp_pkg;

  // Host access state
  typedef enum logic [1:0] {
    shp_idle,
    shp_read,
    shp_write
  } shp_state_e;

endpackage

// ---- rtl/shp_pin_drive.sv ----
`timescale 1ns/1ps
`include "shp_map.svh"

module shp_pin_drive #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Drive style and wanted pin levels
  input wire logic tristate_in,
  input wire logic [W-1:0] level_in,
  input wire logic drive_in,
  // Pin output and output enable
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe_out
);

  logic [W-1:0] next_pin;
  logic [W-1:0] next_pin_oe;

  // Tri-state drives both levels, open drain only pulls low
  always_comb begin
    if (tristate_in == `SHP_DRIVE_TRISTATE) begin
      next_pin = level_in;
      next_pin_oe = {W{drive_in}};
    end else begin
      next_pin = '0;
      next_pin_oe = {W{drive_in}} & ~level_in;
    end
  end

  // Register pin drive
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_out <= '0;
      pin_oe_out <= '0;
    end else begin
      pin_out <= next_pin;
      pin_oe_out <= next_pin_oe;
    end
  end

endmodule // shp_pin_drive

// ---- rtl/shp_host_port.sv ----
`timescale 1ns/1ps
`include "shp_map.svh"

// Function
// - Bus style strap: high split, low direction
// - Interrupt high in split, low in direction
// - Register select connects data bus to registers
// - DMA path select routes data to DMA
// - Five address bits select one register
// - Split style: read strobe drives register data
// - Direction style: read pin gives direction
// - Direction style: write pin is lower strobe
// - Split style: high byte enable gates upper
// - Direction style: upper strobe on high enable
// - Each byte lane carries its own parity
// - Data strap picks data pin drive style
// - Control strap picks control pin drive style
// - REQ and ACK always tri-state
// - Strap low open drain, high tri-state
module shp_host_port (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Straps
  input wire logic bus_style_strap_in,
  input wire logic data_drive_style_strap_in,
  input wire logic control_drive_style_strap_in,
  // Host bus pins
  input wire logic register_select_n_in,
  input wire logic dma_path_select_n_in,
  input wire logic [4:0] addr_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic high_byte_enable_n_in,
  input wire logic [15:0] host_data_in,
  input wire logic upper_lane_parity_in,
  input wire logic lower_lane_parity_in,
  output logic [15:0] host_data_out,
  output logic upper_lane_parity_out,
  output logic lower_lane_parity_out,
  output logic [1:0] host_data_oe_out,
  // Interrupt
  input wire logic irq_in,
  output logic irq_out,
  // Internal register side
  output logic [4:0] reg_addr_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic [1:0] reg_lane_out,
  output logic [15:0] reg_wdata_out,
  output logic [1:0] reg_wpar_out,
  input wire logic [15:0] reg_rdata_in,
  input wire logic [1:0] reg_rpar_in,
  // DMA data bus pins
  input wire logic [15:0] dma_data_in,
  input wire logic [1:0] dma_par_in,
  output logic [15:0] dma_data_out,
  output logic [1:0] dma_par_out,
  output logic [1:0] dma_data_oe_out,
  // SCSI pin levels from the core
  input wire logic [`SHP_SCSI_DATA_W-1:0] scsi_data_level_in,
  input wire logic scsi_data_drive_in,
  input wire logic [`SHP_SCSI_CTRL_W-1:0] scsi_ctrl_level_in,
  input wire logic scsi_ctrl_drive_in,
  input wire logic [`SHP_SCSI_HS_W-1:0] scsi_hs_level_in,
  input wire logic scsi_hs_drive_in,
  // SCSI pins
  output logic [`SHP_SCSI_DATA_W-1:0] scsi_data_out,
  output logic [`SHP_SCSI_DATA_W-1:0] scsi_data_oe_out,
  output logic [`SHP_SCSI_CTRL_W-1:0] scsi_ctrl_out,
  output logic [`SHP_SCSI_CTRL_W-1:0] scsi_ctrl_oe_out,
  output logic [`SHP_SCSI_HS_W-1:0] scsi_hs_out,
  output logic [`SHP_SCSI_HS_W-1:0] scsi_hs_oe_out
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [`SHP_HP_WIDTH-1:0] hp_meta;
  logic [`SHP_HP_WIDTH-1:0] hp;
  logic [17:0] dma_meta;
  logic [17:0] dma_sync;
  logic [2:0] strap_meta;
  logic [2:0] strap_sync;

  // Two flops on every pin before use
  always_ff @(posedge clk_in) begin
    hp_meta <= {upper_lane_parity_in, lower_lane_parity_in, host_data_in, addr_in,
                high_byte_enable_n_in, wr_n_in, rd_n_in, dma_path_select_n_in, register_select_n_in};
    hp <= hp_meta;
    dma_meta <= {dma_par_in, dma_data_in};
    dma_sync <= dma_meta;
    strap_meta <= {control_drive_style_strap_in, data_drive_style_strap_in, bus_style_strap_in};
    strap_sync <= strap_meta;
  end

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic split_style;
  logic data_tristate;
  logic ctrl_tristate;

  // Straps are caught while reset is held and kept afterwards
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      split_style <= strap_sync[0];
      data_tristate <= strap_sync[1];
      ctrl_tristate <= strap_sync[2];
    end
  end

  // ****************************************************************
  // Host strobe decode
  // ****************************************************************
  logic reg_sel;
  logic dma_sel;
  logic rd_act;
  logic wr_act;
  logic [1:0] lanes;

  // Strobes by bus style; register select wins over DMA path
  always_comb begin
    reg_sel = ~hp[`SHP_HP_REGSEL];
    dma_sel = ~hp[`SHP_HP_DMASEL] & hp[`SHP_HP_REGSEL];
    if (split_style == `SHP_STYLE_SPLIT) begin
      rd_act = ~hp[`SHP_HP_RD];
      wr_act = ~hp[`SHP_HP_WR] & hp[`SHP_HP_RD];
      lanes = {~hp[`SHP_HP_BHE], 1'b1};
    end else begin
      lanes = {~hp[`SHP_HP_BHE], ~hp[`SHP_HP_WR]};
      rd_act = hp[`SHP_HP_RD] & (|lanes);
      wr_act = ~hp[`SHP_HP_RD] & (|lanes);
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  shp_pkg::shp_state_e state;
  shp_pkg::shp_state_e next_state;
  logic acc_reg;
  logic next_acc_reg;
  logic [4:0] next_reg_addr;
  logic next_reg_rd;
  logic next_reg_wr;
  logic [1:0] next_reg_lane;
  logic [15:0] next_reg_wdata;
  logic [1:0] next_reg_wpar;

  // Reads pulse at strobe start, writes commit at strobe end
  always_comb begin
    next_state = state;
    next_acc_reg = acc_reg;
    next_reg_addr = reg_addr_out;
    next_reg_rd = 1'b0;
    next_reg_wr = 1'b0;
    next_reg_lane = reg_lane_out;
    next_reg_wdata = reg_wdata_out;
    next_reg_wpar = reg_wpar_out;
    unique case (state)
      shp_pkg::shp_idle: begin
        if ((reg_sel | dma_sel) & rd_act) begin
          next_state = shp_pkg::shp_read;
          next_acc_reg = reg_sel;
          next_reg_addr = hp[`SHP_HP_ADDR_HI:`SHP_HP_ADDR_LO];
          next_reg_lane = lanes;
          next_reg_rd = reg_sel;
        end else if ((reg_sel | dma_sel) & wr_act) begin
          next_state = shp_pkg::shp_write;
          next_acc_reg = reg_sel;
          next_reg_addr = hp[`SHP_HP_ADDR_HI:`SHP_HP_ADDR_LO];
        end
      end
      shp_pkg::shp_read: begin
        next_reg_lane = lanes;
        if (~rd_act) begin
          next_state = shp_pkg::shp_idle;
        end
      end
      shp_pkg::shp_write: begin
        if (wr_act) begin
          next_reg_lane = lanes;
          next_reg_wdata = hp[`SHP_HP_DATA_HI:`SHP_HP_DATA_LO];
          next_reg_wpar = hp[`SHP_HP_PAR_HI:`SHP_HP_PAR_LO];
        end else begin
          next_state = shp_pkg::shp_idle;
          next_reg_wr = acc_reg;
        end
      end
    endcase
  end

  // Register sequencer state
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= shp_pkg::shp_idle;
      acc_reg <= 1'b0;
      reg_addr_out <= `SHP_ADDR_RST;
      reg_rd_out <= 1'b0;
      reg_wr_out <= 1'b0;
      reg_lane_out <= `SHP_LANE_RST;
      reg_wdata_out <= `SHP_DATA_RST;
      reg_wpar_out <= `SHP_PAR_RST;
    end else begin
      state <= next_state;
      acc_reg <= next_acc_reg;
      reg_addr_out <= next_reg_addr;
      reg_rd_out <= next_reg_rd;
      reg_wr_out <= next_reg_wr;
      reg_lane_out <= next_reg_lane;
      reg_wdata_out <= next_reg_wdata;
      reg_wpar_out <= next_reg_wpar;
    end
  end

  // ****************************************************************
  // Data paths and interrupt
  // ****************************************************************
  logic [15:0] next_host_data;
  logic [1:0] next_host_par;
  logic [1:0] next_host_oe;
  logic [15:0] next_dma_data;
  logic [1:0] next_dma_par;
  logic [1:0] next_dma_oe;
  logic next_irq;

  // Host drivers only on selected reads; DMA drivers on DMA-path writes
  always_comb begin
    next_host_data = acc_reg ? reg_rdata_in : dma_sync[15:0];
    next_host_par = acc_reg ? reg_rpar_in : dma_sync[17:16];
    next_host_oe = (state == shp_pkg::shp_read && rd_act) ? lanes : 2'h0;
    next_dma_data = hp[`SHP_HP_DATA_HI:`SHP_HP_DATA_LO];
    next_dma_par = hp[`SHP_HP_PAR_HI:`SHP_HP_PAR_LO];
    next_dma_oe = (state == shp_pkg::shp_write && ~acc_reg && wr_act) ? lanes : 2'h0;
    next_irq = (split_style == `SHP_STYLE_SPLIT) ? irq_in : ~irq_in;
  end

  // Data path registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      host_data_out <= `SHP_DATA_RST;
      upper_lane_parity_out <= 1'b0;
      lower_lane_parity_out <= 1'b0;
      host_data_oe_out <= 2'h0;
      dma_data_out <= `SHP_DATA_RST;
      dma_par_out <= `SHP_PAR_RST;
      dma_data_oe_out <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      host_data_out <= next_host_data;
      upper_lane_parity_out <= next_host_par[`SHP_LANE_HI];
      lower_lane_parity_out <= next_host_par[`SHP_LANE_LO];
      host_data_oe_out <= next_host_oe;
      dma_data_out <= next_dma_data;
      dma_par_out <= next_dma_par;
      dma_data_oe_out <= next_dma_oe;
      irq_out <= next_irq;
    end
  end

  // ****************************************************************
  // SCSI pin drive style
  // ****************************************************************
  // Data pins and parity follow the data strap
  shp_pin_drive #(.W(`SHP_SCSI_DATA_W)) u_data_drive (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tristate_in(data_tristate),
    .level_in(scsi_data_level_in),
    .drive_in(scsi_data_drive_in),
    .pin_out(scsi_data_out),
    .pin_oe_out(scsi_data_oe_out)
  );

  // Message, control/data, input/output and attention follow the control strap
  shp_pin_drive #(.W(`SHP_SCSI_CTRL_W)) u_ctrl_drive (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tristate_in(ctrl_tristate),
    .level_in(scsi_ctrl_level_in),
    .drive_in(scsi_ctrl_drive_in),
    .pin_out(scsi_ctrl_out),
    .pin_oe_out(scsi_ctrl_oe_out)
  );

  // Handshake pins are tri-state whatever the straps say
  shp_pin_drive #(.W(`SHP_SCSI_HS_W)) u_hs_drive (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .tristate_in(`SHP_DRIVE_TRISTATE),
    .level_in(scsi_hs_level_in),
    .drive_in(scsi_hs_drive_in),
    .pin_out(scsi_hs_out),
    .pin_oe_out(scsi_hs_oe_out)
  );

endmodule // shp_host_port

// ---- tb/shp_chk_assertions.sv ----
`timescale 1ns/1ps

// ****************
// Port checker
// ****************
module shp_chk (
  // Clock, reset, straps
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic bus_style_strap_in,
  input wire logic data_drive_style_strap_in,
  // Host side
  input wire logic register_select_n_in,
  input wire logic dma_path_select_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic irq_in,
  input wire logic irq_out,
  input wire logic [1:0] host_data_oe_out,
  input wire logic [1:0] dma_data_oe_out,
  input wire logic reg_rd_out,
  input wire logic reg_wr_out,
  // SCSI side
  input wire logic [8:0] scsi_data_level_in,
  input wire logic scsi_data_drive_in,
  input wire logic [1:0] scsi_hs_level_in,
  input wire logic scsi_hs_drive_in,
  input wire logic [8:0] scsi_data_out,
  input wire logic [8:0] scsi_data_oe_out,
  input wire logic [1:0] scsi_hs_out,
  input wire logic [1:0] scsi_hs_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic [1:0] s;
  logic [1:0] next_s;

  // Straps as caught during reset
  always_comb next_s = rst_in ? {bus_style_strap_in, data_drive_style_strap_in} : s;
  always_ff @(posedge clk_in) s <= next_s;

  // Pin outputs follow their cause one edge later
  property p_irq;
    !$past(rst_in) |-> irq_out == (s[1] ~^ $past(irq_in));
  endproperty
  a_irq: assert property (p_irq) else $error("irq level");
  property p_hs;
    !$past(rst_in) |-> {scsi_hs_out, scsi_hs_oe_out} == {$past(scsi_hs_level_in), {2{$past(scsi_hs_drive_in)}}};
  endproperty
  a_hs: assert property (p_hs) else $error("handshake pins");
  property p_dat;
    !$past(rst_in) |-> scsi_data_out == (s[0] ? $past(scsi_data_level_in) : 9'h000)
      && scsi_data_oe_out == ({9{$past(scsi_data_drive_in)}} & (s[0] ? 9'h1FF : ~$past(scsi_data_level_in)));
  endproperty
  a_dat: assert property (p_dat) else $error("data pins");
  // Register strobes three edges after the pins
  property p_rd;
    reg_rd_out |-> (!$past(register_select_n_in, 3) && $past(rd_n_in, 3) != s[1]) ##1 !reg_rd_out;
  endproperty
  a_rd: assert property (p_rd) else $error("read pulse");
  property p_wr;
    reg_wr_out && s[1] |-> !$past(register_select_n_in, 4) && $past(wr_n_in, 4) < $past(wr_n_in, 3);
  endproperty
  a_wr: assert property (p_wr) else $error("write pulse");
  // Drivers only behind a selected read or path write
  property p_oe;
    |host_data_oe_out |-> (!$past(register_select_n_in, 3) || !$past(dma_path_select_n_in, 3))
      && $past(rd_n_in, 3) != s[1];
  endproperty
  a_oe: assert property (p_oe) else $error("host drive");
  property p_dma;
    |dma_data_oe_out |-> !$past(dma_path_select_n_in, 3) && $past(register_select_n_in, 3);
  endproperty
  a_dma: assert property (p_dma) else $error("path drive");
  property p_wr_quiet;
    reg_wr_out |-> host_data_oe_out == 2'h0;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("drive in write");
endmodule // shp_chk

bind shp_host_port shp_chk u_shp_chk (.*);

// ---- tb/shp_host_model.sv ----
`timescale 1ns/1ps

// ****************
// Host processor
// ****************
module shp_host_model (
  // Clock and style
  input wire logic clk_in,
  input wire logic split_in,
  // Host pins
  output logic rs_n_out,
  output logic ds_n_out,
  output logic [4:0] addr_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic hbe_n_out,
  output logic [17:0] data_out
);
  // Idle bus, upper enable parked at one
  initial begin
    {rs_n_out, ds_n_out, rd_n_out, wr_n_out, hbe_n_out} = 5'h1F;
    addr_out = 5'h00;
    data_out = 18'h00000;
  end

  // Start one access and hold it
  task automatic go(input logic dma, input logic wr, input logic up, input logic [4:0] a, input logic [17:0] d);
    @(negedge clk_in);
    {rs_n_out, ds_n_out} <= {dma, !dma};
    addr_out <= a;
    data_out <= d;
    hbe_n_out <= !up;
    rd_n_out <= split_in ? wr : !wr;
    wr_n_out <= split_in && !wr;
  endtask

  // Drop strobes, then selects, then idle
  task automatic stop();
    repeat (3) @(negedge clk_in);
    {rd_n_out, wr_n_out, hbe_n_out} <= 3'h7;
    @(negedge clk_in);
    {rs_n_out, ds_n_out} <= 2'h3;
    data_out <= ~data_out; // No stale value once released
    repeat (4) @(negedge clk_in);
  endtask
endmodule // shp_host_model

// ---- tb/tb_shp_host_port.sv ----
`timescale 1ns/1ps

// ****************
// Host port bench
// ****************
module tb_shp_host_port;
  logic clk_in = 1'b0, rst_in = 1'b1, irq_in = 1'b0;
  logic bus_style_strap_in = 1'b1, data_drive_style_strap_in = 1'b1, control_drive_style_strap_in = 1'b0;
  logic register_select_n_in, dma_path_select_n_in, rd_n_in, wr_n_in, high_byte_enable_n_in;
  logic [4:0] addr_in;
  logic [15:0] host_data_in, reg_rdata_in = 16'h0000, dma_data_in = 16'h0000;
  logic upper_lane_parity_in, lower_lane_parity_in;
  logic [17:0] hdat;
  logic [1:0] reg_rpar_in = 2'h0, dma_par_in = 2'h0, scsi_hs_level_in = 2'h0;
  logic [8:0] scsi_data_level_in = 9'h000;
  logic [3:0] scsi_ctrl_level_in = 4'h0;
  logic scsi_data_drive_in = 1'b0, scsi_ctrl_drive_in = 1'b0, scsi_hs_drive_in = 1'b0;
  logic [15:0] host_data_out, reg_wdata_out, dma_data_out;
  logic upper_lane_parity_out, lower_lane_parity_out, irq_out, reg_rd_out, reg_wr_out;
  logic [1:0] host_data_oe_out, reg_lane_out, reg_wpar_out, dma_par_out, dma_data_oe_out;
  logic [4:0] reg_addr_out;
  logic [8:0] scsi_data_out, scsi_data_oe_out;
  logic [3:0] scsi_ctrl_out, scsi_ctrl_oe_out;
  logic [1:0] scsi_hs_out, scsi_hs_oe_out;
  int fails = 0, num_checks = 0, pulses = 0, n;

  // Block and host
  shp_host_port u_shp_host_port (.*);
  shp_host_model u_shp_host_model (.clk_in(clk_in), .split_in(bus_style_strap_in),
    .rs_n_out(register_select_n_in), .ds_n_out(dma_path_select_n_in), .addr_out(addr_in),
    .rd_n_out(rd_n_in), .wr_n_out(wr_n_in), .hbe_n_out(high_byte_enable_n_in), .data_out(hdat));
  assign {upper_lane_parity_in, lower_lane_parity_in, host_data_in} = hdat;

  // Clock and strobe pulse count
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) pulses += int'(reg_rd_out === 1'b1) + int'(reg_wr_out === 1'b1);

  // Compare and count
  task automatic chk(input logic [17:0] seen, input logic [17:0] want);
    num_checks++;
    if (seen !== want) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset with straps steady
  task automatic do_reset(input logic s);
    @(negedge clk_in);
    rst_in = 1'b1;
    {bus_style_strap_in, data_drive_style_strap_in, control_drive_style_strap_in} = {s, s, !s};
    repeat (5) @(negedge clk_in);
    rst_in = 1'b0;
  endtask

  // Register read at top address, both lanes
  task automatic t_rd();
    n = pulses;
    {reg_rpar_in, reg_rdata_in} = 18'h2A55A;
    u_shp_host_model.go(1'b0, 1'b0, 1'b1, 5'h1F, 18'h00000);
    repeat (5) @(negedge clk_in);
    chk({upper_lane_parity_out, lower_lane_parity_out, host_data_out}, 18'h2A55A);
    chk({host_data_oe_out, reg_lane_out, reg_addr_out}, 18'h1FF);
    u_shp_host_model.stop();
    chk(18'({host_data_oe_out, 5'(pulses - n)}), 18'h01);
  endtask

  // Register write, lower lane only
  task automatic t_wr();
    n = pulses;
    u_shp_host_model.go(1'b0, 1'b1, 1'b0, 5'h00, 18'h1C3A5);
    u_shp_host_model.stop();
    chk(18'({5'(pulses - n), reg_lane_out, reg_addr_out}), 18'hA0);
    chk({reg_wpar_out[0], reg_wdata_out[7:0]}, 18'h1A5);
  endtask

  // Path read and write, no register strobes
  task automatic t_dma();
    n = pulses;
    {dma_par_in, dma_data_in} = 18'h10F0F;
    u_shp_host_model.go(1'b1, 1'b0, 1'b1, 5'h0A, 18'h00000);
    repeat (5) @(negedge clk_in);
    chk({upper_lane_parity_out, lower_lane_parity_out, host_data_out}, 18'h10F0F);
    chk({dma_data_oe_out, host_data_oe_out}, 18'h3);
    u_shp_host_model.stop();
    u_shp_host_model.go(1'b1, 1'b1, 1'b1, 5'h0A, 18'h3C3C3);
    repeat (5) @(negedge clk_in);
    chk({dma_par_out, dma_data_out}, 18'h3C3C3);
    chk({dma_data_oe_out, host_data_oe_out}, 18'hC);
    u_shp_host_model.stop();
    chk(18'(pulses - n), 18'h0);
  endtask

  // Interrupt polarity and SCSI drive styles
  task automatic t_side(input logic s);
    irq_in = 1'b1;
    {scsi_data_level_in, scsi_ctrl_level_in, scsi_hs_level_in} = 15'h2959;
    {scsi_data_drive_in, scsi_ctrl_drive_in, scsi_hs_drive_in} = 3'h7;
    repeat (2) @(negedge clk_in);
    chk(18'(irq_out), 18'(s));
    chk({scsi_data_out, scsi_data_oe_out}, s ? 18'h14BFF : 18'h0015A);
    chk(18'({scsi_ctrl_out, scsi_ctrl_oe_out, scsi_hs_out, scsi_hs_oe_out}), s ? 18'h97 : 18'h6F7);
    irq_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(18'(irq_out), 18'(!s));
  endtask

  // Both bus styles in turn
  initial begin
    for (int i = 0; i < 2; i++) begin
      do_reset(i == 0);
      t_rd();
      t_wr();
      t_dma();
      t_side(i == 0);
    end
    close_out();
  end

  // Watchdog, far beyond the roughly 122 cycles needed
  initial begin
    #40000;
    fails++;
    close_out();
  end
endmodule // tb_shp_host_port
